// >>> src/scs_pkg.sv
package scs_pkg;

  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned TICK_NS       = 1000;
  localparam int unsigned TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;
  localparam logic [7:0]  TICK_LAST     = 8'(TICK_CYCLES - 1);
  localparam int unsigned US_PER_MS     = 1000;
  localparam logic [9:0]  US_LAST       = 10'(US_PER_MS - 1);

  // Service times are kept in microseconds.
  localparam logic [15:0] SVC_MIN_BOARD_US  = 16'h0104;
  localparam logic [15:0] SVC_MIN_SERIAL_US = 16'h00e4;
  localparam logic [15:0] SVC_MAX_US        = 16'he38e;
  localparam logic [15:0] SVC_STOP_US       = 16'h2710;
  localparam logic [6:0]  SVC_DEFAULT_PCT   = 7'h05;
  localparam logic [30:0] PCT_FULL          = 31'h0000_0064;
  localparam logic [7:0]  SVC_EN_ON         = 8'h01;

  localparam logic [7:0]  MON_UNIT_10MS  = 8'h01;
  localparam logic [7:0]  MON_UNIT_100MS = 8'h02;
  localparam logic [7:0]  MON_UNIT_1S    = 8'h03;
  localparam logic [16:0] MON_FIXED_MS   = 17'h00078;
  localparam logic [16:0] MON_MAX_MS     = 17'h182b8;
  localparam logic [16:0] MON_10_MS      = 17'h0000a;
  localparam logic [16:0] MON_100_MS     = 17'h00064;
  localparam logic [16:0] MON_1000_MS    = 17'h003e8;

  localparam int unsigned REFRESH_UNITS = 10;
  localparam int unsigned IRQ_MODE_LSB  = 12;
  localparam logic [3:0]  IRQ_MODE_FAST = 4'h1;

  localparam logic [13:0] IDX_BOARD_A  = 14'h19d6;
  localparam logic [13:0] IDX_RSVD     = 14'h19d7;
  localparam logic [13:0] IDX_SERIAL   = 14'h19d8;
  localparam logic [13:0] IDX_PERIPH   = 14'h19d9;
  localparam logic [13:0] IDX_MONITOR  = 14'h19da;
  localparam logic [13:0] IDX_MIN_CYC  = 14'h19db;
  localparam logic [13:0] IDX_REFRESH  = 14'h19dc;
  localparam logic [13:0] IDX_CTRL     = 14'h19e0;
  localparam logic [13:0] IDX_STATUS   = 14'h19e1;
  localparam logic [13:0] IDX_BUD_A    = 14'h19e2;
  localparam logic [13:0] IDX_BUD_SER  = 14'h19e3;
  localparam logic [13:0] IDX_BUD_PER  = 14'h19e4;
  localparam logic [13:0] IDX_LAST_MS  = 14'h19e5;

  localparam logic [15:0] SETUP_RST    = 16'h0000;
  localparam int unsigned CTRL_RUN_BIT = 0;
  localparam int unsigned STAT_OVR_BIT = 0;

  typedef enum logic [1:0] {
    SCS_STOP = 2'b00,
    SCS_SCAN = 2'b01,
    SCS_PAD  = 2'b11
  } scs_phase_t;

  typedef struct packed {
    logic [15:0] board_a;
    logic [15:0] serial;
    logic [15:0] periph;
  } scs_budget_t;

  typedef struct packed {
    logic [15:0] board_a;
    logic [15:0] serial;
    logic [15:0] periph;
    logic [15:0] monitor;
    logic [15:0] min_cycle;
    logic [15:0] refresh;
  } scs_setup_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [15:0] paddr;
    logic [31:0] pwdata;
  } scs_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } scs_apb_rsp_t;

endpackage : scs_pkg

// >>> src/scs_scheduler.sv
`timescale 1ns/1ps
module scs_scheduler
  import scs_pkg::*;
(
  input  wire logic                       clock,
  input  wire logic                       rst_n,
  input  wire scs_apb_req_t               apb_req,
  output scs_apb_rsp_t                    apb_rsp,
  input  wire logic                       scan_done,
  input  wire logic                       core_busy,
  input  wire logic                       irq_req,
  input  wire logic [REFRESH_UNITS-1:0]   unit_remote,
  output logic                            cycle_start,
  output scs_budget_t                     budget,
  output logic [REFRESH_UNITS-1:0]        refresh_enable,
  output logic                            irq_go,
  output logic                            irq_preempt,
  output logic                            overrun,
  output logic                            running
);

  typedef struct packed {
    scs_phase_t                 phase;
    scs_setup_t                 sw;
    scs_setup_t                 lat;
    logic                       run_ctl;
    logic                       run_d;
    logic [7:0]                 tick_cnt;
    logic [9:0]                 us_cnt;
    logic [23:0]                el_us;
    logic [16:0]                el_ms;
    logic [15:0]                last_ms;
    scs_budget_t                bud;
    logic                       ovr;
    logic                       ovr_cyc;
    logic                       start_p;
    logic                       irq_pend;
    logic                       irq_go;
    logic                       irq_pre;
    logic [REFRESH_UNITS-1:0]   refr;
    logic [31:0]                prdata;
    logic                       pslverr;
  } scs_state_t;

  scs_state_t  state_reg;
  scs_state_t  state_next;
  logic [1:0]  rst_sync_reg;
  logic        rst_core_n;

  // Reset is released through two stages so the release is clean to the clock.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_reg <= 2'b00;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_core_n = rst_sync_reg[1];

  function automatic logic [6:0] bcd2(input logic [7:0] v);
    return 7'(v[7:4]) * 7'h0a + 7'(v[3:0]);
  endfunction : bcd2

  function automatic logic [13:0] bcd4(input logic [15:0] v);
    return 14'(v[15:12]) * 14'h03e8 + 14'(v[11:8]) * 14'h0064
         + 14'(v[7:4]) * 14'h000a + 14'(v[3:0]);
  endfunction : bcd4

  // The share is taken of the cycle that just ended, so a budget lags by one scan.
  function automatic logic [15:0] svc_time(input logic [15:0] w,
                                           input logic [23:0] cyc,
                                           input logic [15:0] lo);
    logic [6:0]  pct;
    logic [30:0] prod;
    logic [23:0] t;
    pct  = (w[15:8] == SVC_EN_ON) ? bcd2(w[7:0]) : SVC_DEFAULT_PCT;
    prod = 31'(cyc) * 31'(pct);
    t    = 24'(prod / PCT_FULL);
    if (t < 24'(lo)) begin
      t = 24'(lo);
    end else if (t > 24'(SVC_MAX_US)) begin
      t = 24'(SVC_MAX_US);
    end
    return t[15:0];
  endfunction : svc_time

  function automatic logic [16:0] mon_limit(input logic [15:0] w);
    logic [16:0] lim;
    case (w[15:8])
      MON_UNIT_10MS:  lim = 17'(bcd2(w[7:0])) * MON_10_MS;
      MON_UNIT_100MS: lim = 17'(bcd2(w[7:0])) * MON_100_MS;
      MON_UNIT_1S:    lim = 17'(bcd2(w[7:0])) * MON_1000_MS;
      default:        lim = MON_FIXED_MS;
    endcase
    if (lim > MON_MAX_MS) begin
      lim = MON_MAX_MS;
    end
    return lim;
  endfunction : mon_limit

  logic        us_tick;
  logic        ms_tick;
  logic        fast_mode;
  logic        run_start;
  logic        new_cycle;
  logic        min_met;
  logic [13:0] addr_idx;
  logic        addr_hit;
  logic [31:0] rd_val;
  logic        apb_setup;
  logic        apb_write;

  always_comb begin
    state_next = state_reg;
    us_tick    = 1'b0;
    ms_tick    = 1'b0;
    new_cycle  = 1'b0;
    state_next.start_p = 1'b0;
    state_next.irq_go  = 1'b0;
    state_next.irq_pre = 1'b0;
    fast_mode = state_reg.lat.refresh[IRQ_MODE_LSB +: 4] == IRQ_MODE_FAST;
    run_start = state_reg.run_ctl & ~state_reg.run_d;
    min_met   = state_reg.el_ms >= 17'(bcd4(state_reg.lat.min_cycle));
    state_next.run_d = state_reg.run_ctl;

    // Microsecond and millisecond time base.
    if (state_reg.tick_cnt == TICK_LAST) begin
      state_next.tick_cnt = 8'h00;
      us_tick = 1'b1;
    end else begin
      state_next.tick_cnt = state_reg.tick_cnt + 8'h01;
    end
    if (us_tick) begin
      if (state_reg.us_cnt == US_LAST) begin
        state_next.us_cnt = 10'h000;
        ms_tick = 1'b1;
      end else begin
        state_next.us_cnt = state_reg.us_cnt + 10'h001;
      end
    end
    if (us_tick && state_reg.el_us != 24'hff_ffff) begin
      state_next.el_us = state_reg.el_us + 24'h00_0001;
    end
    if (ms_tick && state_reg.el_ms != 17'h1ffff) begin
      state_next.el_ms = state_reg.el_ms + 17'h00001;
    end

    // Register bus decode.
    addr_idx  = apb_req.paddr[15:2];
    apb_setup = apb_req.psel & ~apb_req.penable;
    apb_write = apb_req.psel & apb_req.penable & apb_req.pwrite;
    addr_hit  = apb_req.paddr[1:0] == 2'b00;
    rd_val    = 32'h0000_0000;
    case (addr_idx)
      IDX_BOARD_A: rd_val[15:0] = state_reg.sw.board_a;
      IDX_RSVD:    rd_val[15:0] = 16'h0000;
      IDX_SERIAL:  rd_val[15:0] = state_reg.sw.serial;
      IDX_PERIPH:  rd_val[15:0] = state_reg.sw.periph;
      IDX_MONITOR: rd_val[15:0] = state_reg.sw.monitor;
      IDX_MIN_CYC: rd_val[15:0] = state_reg.sw.min_cycle;
      IDX_REFRESH: rd_val[15:0] = state_reg.sw.refresh;
      IDX_CTRL:    rd_val[0]    = state_reg.run_ctl;
      IDX_STATUS:  rd_val[2:0]  = {fast_mode, state_reg.phase != SCS_STOP, state_reg.ovr};
      IDX_BUD_A:   rd_val[15:0] = state_reg.bud.board_a;
      IDX_BUD_SER: rd_val[15:0] = state_reg.bud.serial;
      IDX_BUD_PER: rd_val[15:0] = state_reg.bud.periph;
      IDX_LAST_MS: rd_val[15:0] = state_reg.last_ms;
      default:     addr_hit     = 1'b0;
    endcase
    if (apb_setup) begin
      state_next.prdata  = apb_req.pwrite ? 32'h0000_0000 : rd_val;
      state_next.pslverr = ~addr_hit;
    end
    if (apb_write && addr_hit) begin
      case (addr_idx)
        IDX_BOARD_A: state_next.sw.board_a   = apb_req.pwdata[15:0];
        IDX_SERIAL:  state_next.sw.serial    = apb_req.pwdata[15:0];
        IDX_PERIPH:  state_next.sw.periph    = apb_req.pwdata[15:0];
        IDX_MONITOR: state_next.sw.monitor   = apb_req.pwdata[15:0];
        IDX_MIN_CYC: state_next.sw.min_cycle = apb_req.pwdata[15:0];
        IDX_REFRESH: state_next.sw.refresh   = apb_req.pwdata[15:0];
        IDX_CTRL:    state_next.run_ctl      = apb_req.pwdata[CTRL_RUN_BIT];
        IDX_STATUS: begin
          if (apb_req.pwdata[STAT_OVR_BIT]) begin
            state_next.ovr = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end

    // Scan sequencing.
    case (state_reg.phase)
      SCS_STOP: begin
        state_next.bud = '{SVC_STOP_US, SVC_STOP_US, SVC_STOP_US};
        if (run_start) begin
          state_next.lat   = state_reg.sw;
          state_next.phase = SCS_SCAN;
          new_cycle = 1'b1;
        end
      end
      SCS_SCAN: begin
        if (!state_reg.run_ctl) begin
          state_next.phase = SCS_STOP;
        end else if (scan_done) begin
          if (min_met) begin
            new_cycle = 1'b1;
          end else begin
            state_next.phase = SCS_PAD;
          end
        end
      end
      SCS_PAD: begin
        if (!state_reg.run_ctl) begin
          state_next.phase = SCS_STOP;
        end else if (min_met) begin
          state_next.phase = SCS_SCAN;
          new_cycle = 1'b1;
        end
      end
      default: begin
        state_next.phase = SCS_STOP;
      end
    endcase

    if (new_cycle) begin
      state_next.start_p = 1'b1;
      state_next.el_us   = 24'h00_0000;
      state_next.el_ms   = 17'h00000;
      state_next.ovr_cyc = 1'b0;
      if (state_reg.phase != SCS_STOP) begin
        state_next.last_ms = (state_reg.el_ms > 17'h0ffff) ? 16'hffff
                                                            : state_reg.el_ms[15:0];
        state_next.bud.board_a = svc_time(state_reg.lat.board_a, state_reg.el_us,
                                          SVC_MIN_BOARD_US);
        state_next.bud.serial  = svc_time(state_reg.lat.serial, state_reg.el_us,
                                          SVC_MIN_SERIAL_US);
        state_next.bud.periph  = svc_time(state_reg.lat.periph, state_reg.el_us,
                                          SVC_MIN_BOARD_US);
      end
    end

    // Overrun is raised once per cycle; it is checked after the clear so a
    // coincident software clear cannot swallow it.
    if (state_reg.phase != SCS_STOP && !new_cycle && !state_reg.ovr_cyc &&
        state_reg.el_ms > mon_limit(state_reg.lat.monitor)) begin
      state_next.ovr     = 1'b1;
      state_next.ovr_cyc = 1'b1;
    end

    // Remote rack units are always refreshed, as are all units in normal mode.
    if (fast_mode) begin
      state_next.refr = ~state_reg.lat.refresh[REFRESH_UNITS-1:0] | unit_remote;
    end else begin
      state_next.refr = '1;
    end

    // Interrupt acceptance.
    if (irq_req || state_reg.irq_pend) begin
      if (fast_mode || !core_busy) begin
        state_next.irq_go   = 1'b1;
        state_next.irq_pre  = core_busy;
        state_next.irq_pend = 1'b0;
      end else begin
        state_next.irq_pend = 1'b1;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_core_n) begin
    if (!rst_core_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign apb_rsp.pready  = 1'b1;
  assign apb_rsp.pslverr = state_reg.pslverr;
  assign apb_rsp.prdata  = state_reg.prdata;
  assign cycle_start     = state_reg.start_p;
  assign budget          = state_reg.bud;
  assign refresh_enable  = state_reg.refr;
  assign irq_go          = state_reg.irq_go;
  assign irq_preempt     = state_reg.irq_pre;
  assign overrun         = state_reg.ovr;
  assign running         = state_reg.phase != SCS_STOP;

endmodule : scs_scheduler

// >>> tb/scs_core_model.sv
`timescale 1ns/1ps
// Stands in for the processor core: each scan lasts scan_len clocks after a cycle start.
module scs_core_model (
  input  logic clock,
  input  logic cycle_start,
  input  int   scan_len,
  input  logic busy_cmd,
  output logic scan_done,
  output logic core_busy
);
  int cnt = 0;
  initial begin
    scan_done = 1'b0;
    core_busy = 1'b0;
  end
  always @(posedge clock) begin
    scan_done <= 1'b0;
    core_busy <= busy_cmd;
    if (cycle_start) begin
      cnt <= scan_len;
    end else if (cnt > 0) begin
      cnt       <= cnt - 1;
      scan_done <= (cnt == 1);
    end
  end
endmodule : scs_core_model

// >>> tb/scs_scheduler_monitor.sv
`timescale 1ns/1ps
module scs_scheduler_monitor
  import scs_pkg::*;
(
  input logic                     clock,
  input logic                     rst_n,
  input scs_apb_req_t             apb_req,
  input scs_apb_rsp_t             apb_rsp,
  input logic                     scan_done,
  input logic                     core_busy,
  input logic                     irq_req,
  input logic [REFRESH_UNITS-1:0] unit_remote,
  input logic                     cycle_start,
  input scs_budget_t              budget,
  input logic [REFRESH_UNITS-1:0] refresh_enable,
  input logic                     irq_go,
  input logic                     irq_preempt,
  input logic                     overrun,
  input logic                     running
);
  logic [2:0] age_reg;
  logic       clr;
  // The refresh outputs settle a few edges after reset; age_reg holds the check off.
  assign clr = apb_req.psel && apb_req.penable && apb_req.pwrite && apb_req.pwdata[0]
               && apb_req.paddr == {IDX_STATUS, 2'b00};
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) age_reg <= 3'h0;
    else if (age_reg != 3'h7) age_reg <= age_reg + 3'h1;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence s_idle_req;
    irq_req && !core_busy;
  endsequence
  sequence s_run_stops;
    running ##1 !running;
  endsequence
  a_irq_idle_prompt: assert property (s_idle_req |=> irq_go)
    else $error("idle interrupt not taken");
  a_irq_deferred: assert property (irq_go && !irq_preempt |-> !$past(core_busy))
    else $error("interrupt ran during busy work");
  a_preempt_busy: assert property (irq_preempt |-> irq_go && $past(core_busy))
    else $error("preempt without busy work");
  a_stop_budget: assert property (s_run_stops |=> budget == {3{SVC_STOP_US}})
    else $error("stop budget wrong");
  a_budget_bounds: assert property (running |->
    budget.board_a inside {[SVC_MIN_BOARD_US:SVC_MAX_US]} &&
    budget.periph inside {[SVC_MIN_BOARD_US:SVC_MAX_US]} &&
    budget.serial inside {[SVC_MIN_SERIAL_US:SVC_MAX_US]}) else $error("budget out of range");
  a_budget_hold: assert property (running && $past(running) && !cycle_start |->
    $stable(budget)) else $error("budget moved mid cycle");
  a_remote_refresh: assert property (age_reg == 3'h7 |->
    (refresh_enable & $past(unit_remote)) == $past(unit_remote))
    else $error("remote unit not refreshed");
  a_overrun_sticky: assert property (overrun && !clr |=> overrun)
    else $error("overrun flag lost");
  a_cycle_pulse: assert property (cycle_start |-> running ##1 !cycle_start)
    else $error("cycle start not a single pulse");
endmodule : scs_scheduler_monitor

bind scs_scheduler scs_scheduler_monitor scs_scheduler_monitor_inst (.clock, .rst_n,
  .apb_req, .apb_rsp, .scan_done, .core_busy, .irq_req, .unit_remote, .cycle_start,
  .budget, .refresh_enable, .irq_go, .irq_preempt, .overrun, .running);

// >>> tb/tb.sv
`timescale 1ns/1ps
module tb
  import scs_pkg::*;
;
  logic                     clock, rst_n, scan_done, core_busy, irq_req, cycle_start;
  logic                     irq_go, irq_preempt, overrun, running, busy_cmd, err, sd;
  logic [REFRESH_UNITS-1:0] unit_remote, refresh_enable;
  scs_apb_req_t             apb_req;
  scs_apb_rsp_t             apb_rsp;
  scs_budget_t              budget;
  logic [31:0]              rnd, rd;
  logic [13:0]              idxs [6];
  int                       miscompares = 0, cmp_count = 0, scan_len, n, us;

  always #2.5 clock = ~clock;
  scs_scheduler scs_scheduler_inst (.clock, .rst_n, .apb_req, .apb_rsp, .scan_done,
    .core_busy, .irq_req, .unit_remote, .cycle_start, .budget, .refresh_enable, .irq_go,
    .irq_preempt, .overrun, .running);
  scs_core_model scs_core_model_inst (.clock, .cycle_start, .scan_len, .busy_cmd,
    .scan_done, .core_busy);

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic int bdg(input logic [15:0] w, input int prev, input int lo);
    int p;
    p = (w[15:8] == 8'h01) ? w[7:4] * 10 + w[3:0] : 5;
    p = p * prev / 100;
    return p < lo ? lo : (p > 58254 ? 58254 : p);
  endfunction : bdg
  task finish_test;
    $display("comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : finish_test
  // Wide enough for the whole budget bundle and for a response code joined to read data.
  task chk(input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk
  // The design counts cycle time on a free-running microsecond tick, so allow 2 us.
  task near(input logic [15:0] seen, input int exp);
    chk(seen + 2 >= exp && seen <= exp + 2, 1);
  endtask : near
  task apb(input logic w, input logic [13:0] idx, input logic [15:0] d);
    @(posedge clock);
    apb_req <= '{1'b1, 1'b0, w, {idx, 2'b00}, {16'h0000, d}};
    @(posedge clock);
    apb_req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (apb_rsp.pready !== 1'b1 && n < 20);
    if (n == 20) begin
      miscompares++;
      finish_test;
    end
    rd = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req <= '0;
  endtask : apb
  task wcs(input int lim);
    n = 0;
    do begin
      @(posedge clock);
      #1;
      n++;
      if (cycle_start !== 1'b1) sd = scan_done;
    end while (cycle_start !== 1'b1 && n < lim);
    if (n == lim) begin
      miscompares++;
      finish_test;
    end
  endtask : wcs
  task irqt(input logic fast);
    int g, p;
    g = 0;
    p = 0;
    busy_cmd <= 1'b1;
    repeat (2) @(posedge clock);
    irq_req <= 1'b1;
    // The request edge is the first one looked at, so a one-cycle pulse right after it is seen.
    repeat (8) begin
      @(posedge clock);
      irq_req <= 1'b0;
      #1;
      if (irq_go === 1'b1) g++;
      if (irq_preempt === 1'b1) p++;
      if (g + p == 0) busy_cmd <= 1'b0;
      if (busy_cmd === 1'b1 && !fast) chk(g, 0);
    end
    busy_cmd <= 1'b0;
    chk(g, 1);
    chk(p, fast);
  endtask : irqt
  task stop;
    apb(1'b1, IDX_CTRL, 16'h0000);
    repeat (3) @(posedge clock);
    chk(running, 0);
    chk(budget, {3{SVC_STOP_US}});
  endtask : stop

  initial begin
    clock = 0; rst_n = 0; apb_req = '0; irq_req = 0; busy_cmd = 0; unit_remote = '0;
    scan_len = 60000; sd = 0; rnd = 32'hc81eac79;
    idxs = '{IDX_BOARD_A, IDX_SERIAL, IDX_PERIPH, IDX_MONITOR, IDX_MIN_CYC, IDX_REFRESH};
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    repeat (4) @(posedge clock);
    chk(budget, {3{SVC_STOP_US}});
    for (int i = 0; i < 6; i++) begin
      rnd = lfsr(rnd);
      apb(1'b0, idxs[i], 16'h0000);
      chk(rd, 0);
      apb(1'b1, idxs[i], rnd[15:0]);
      apb(1'b0, idxs[i], 16'h0000);
      chk(rd, {16'h0000, rnd[15:0]});
    end
    apb(1'b1, IDX_RSVD, 16'hffff);
    apb(1'b0, IDX_RSVD, 16'h0000);
    chk({err, rd}, 0);
    apb(1'b0, 14'h1000, 16'h0000);
    chk(err, 1);
    $display("test registers done");
    rnd = lfsr(rnd);
    unit_remote <= rnd[9:0];
    apb(1'b1, IDX_BOARD_A, 16'h0199);
    apb(1'b1, IDX_SERIAL, 16'h0199);
    apb(1'b1, IDX_PERIPH, 16'h0099);
    apb(1'b1, IDX_MONITOR, 16'h0399);
    apb(1'b1, IDX_MIN_CYC, 16'h0000);
    apb(1'b1, IDX_REFRESH, 16'h12a5);
    apb(1'b1, IDX_CTRL, 16'h0001);
    wcs(20);
    // A 300 us scan lifts the 99 percent share above its floor, so the share itself is checked.
    wcs(70000);
    chk(sd, 1);
    us = n / 200;
    near(budget.board_a, bdg(16'h0199, us, 260));
    near(budget.serial, bdg(16'h0199, us, 228));
    near(budget.periph, bdg(16'h0099, us, 260));
    chk(refresh_enable, {22'h0, ~10'h2a5 | unit_remote});
    apb(1'b1, IDX_REFRESH, 16'h0000);
    repeat (2) @(posedge clock);
    chk(refresh_enable, {22'h0, ~10'h2a5 | unit_remote});
    apb(1'b0, IDX_STATUS, 16'h0000);
    chk(rd, 32'h0000_0006);
    chk(overrun, 0);
    irqt(1'b1);
    stop;
    scan_len <= 200;
    $display("test high-speed run done");
    apb(1'b1, IDX_BOARD_A, 16'h0000);
    apb(1'b1, IDX_SERIAL, 16'h0000);
    apb(1'b1, IDX_PERIPH, 16'h0100);
    apb(1'b1, IDX_REFRESH, 16'h02a5);
    apb(1'b1, IDX_CTRL, 16'h0001);
    wcs(20);
    wcs(400);
    us = n / 200;
    near(budget.board_a, bdg(16'h0000, us, 260));
    near(budget.serial, bdg(16'h0000, us, 228));
    near(budget.periph, bdg(16'h0100, us, 260));
    chk(refresh_enable, {22'h0, 10'h3ff});
    irqt(1'b0);
    stop;
    $display("test normal run done");
    finish_test;
  end
endmodule : tb
